//--- pkg/lfmc_params.svh
// Purpose: offsets, field positions, reset values of the filter/margin bank
// Assumes: 8-bit register port, byte addressed by register number
// Notes:   definitions only
`ifndef LFMC_PARAMS_SVH
`define LFMC_PARAMS_SVH

// register offsets
`define LFMC_ADDR_CAP1       8'h53
`define LFMC_ADDR_RES3       8'h54
`define LFMC_ADDR_CAP3       8'h55
`define LFMC_ADDR_MARGIN     8'h56
`define LFMC_ADDR_STEP_BASE  8'h58
`define LFMC_ADDR_STEP_LAST  8'h67
`define LFMC_ADDR_SW_HI      8'h68
`define LFMC_ADDR_SW_LO      8'h69

// field positions
`define LFMC_CAP_MSB         2
`define LFMC_CAP_LSB         0
`define LFMC_RES_MSB         6
`define LFMC_RES_LSB         1
`define LFMC_FRAC_BIT        0
`define LFMC_STEP_MSB        6
`define LFMC_STEP_LSB        4
`define LFMC_SRC_MSB         3
`define LFMC_SRC_LSB         2

// reset values
`define LFMC_RST_CAP         3'h0
`define LFMC_RST_RES         6'h00
`define LFMC_RST_FRAC        1'h0
`define LFMC_RST_SRC         2'h0
`define LFMC_RST_SW          10'h000
`define LFMC_RST_STEP1       10'h0de
`define LFMC_RST_STEP2       10'h118
`define LFMC_RST_STEP3       10'h14b
`define LFMC_RST_NOMINAL_OFFSET_STEP       10'h186
`define LFMC_RST_STEP5       10'h1be
`define LFMC_RST_STEP6       10'h1fe
`define LFMC_RST_STEP7       10'h247
`define LFMC_RST_STEP8       10'h29e

// nominal step code
`define LFMC_NOMINAL_STEP    3'h3

`endif

//--- pkg/lfmc_pkg.sv
// Purpose: types of the filter/margin register bank
// Assumes: constants come from lfmc_params.svh
// Notes:   none
package lfmc_pkg;

  typedef enum logic [1:0] {
    LFMC_SRC_GATED  = 2'h0,
    LFMC_SRC_SELECT = 2'h1,
    LFMC_SRC_SW     = 2'h2,
    LFMC_SRC_SPARE  = 2'h3
  } lfmc_src_t;

  typedef struct packed {
    logic [2:0] synth2FilterCapFirst;
    logic [5:0] synth2FilterResThird;
    logic [2:0] synth2FilterCapThird;
    logic       synth2FilterFracSelect;
  } lfmc_filter_t;

  typedef struct packed {
    logic       active;
    logic [2:0] step;
    logic [9:0] offset;
  } lfmc_margin_t;

endpackage

//--- core/lfmc_regs.sv
// Purpose: second synthesizer loop filter and crystal margining registers
// Assumes: single clock, margin pins asynchronous to clk
// Notes:   read data valid only in the cycle after the read strobe
//
// Function
// - first filter capacitor: 3-bit RW code in bits [2:0].
// - third filter capacitor: 3-bit RW code, 5 pF per count.
// - third filter resistor: 6-bit RW code in bits [6:1].
// - bit [0] RW filter mode: 0 integer, 1 fractional, resets 0.
// - margin register bits [6:4] read the margin-select pin level after its two-flop synchroniser.
// - step codes 0..7 mean steps one..eight; code 3 is nominal.
// - source 0: margining enabled only while enable pin low.
// - source 0 with enable pin high applies nominal step four offset.
// - source 1: select pin picks step; enable pin ignored.
// - source 2: offset taken from software offset register.
// - eight 10-bit step offsets, split over two byte registers each.
`timescale 1ns/10ps
`default_nettype none
`include "lfmc_params.svh"

module lfmc_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // register port
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output var  logic [7:0]           rdata,
  // board margining pins
  input  wire logic                 marginEnablePin,
  input  wire logic [2:0]           marginSelectPin,
  // synthesizer and crystal controls
  output var  lfmc_pkg::lfmc_filter_t filterCfg,
  output var  lfmc_pkg::lfmc_margin_t marginOut
);
  import lfmc_pkg::*;

  localparam logic [9:0] SW_RST = `LFMC_RST_SW;

  localparam logic [9:0] STEP_RST [8] = '{
    `LFMC_RST_STEP1, `LFMC_RST_STEP2, `LFMC_RST_STEP3, `LFMC_RST_NOMINAL_OFFSET_STEP,
    `LFMC_RST_STEP5, `LFMC_RST_STEP6, `LFMC_RST_STEP7, `LFMC_RST_STEP8
  };

  // stored state
  lfmc_src_t  marginSrc;
  logic [1:0] stepHi [8];
  logic [7:0] stepLo [8];
  logic [1:0] swHi;
  logic [7:0] swLo;

  // pin synchronisers
  logic       enMeta;
  logic       enSync;
  logic [2:0] selMeta;
  logic [2:0] selSync;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enMeta  <= 1'h1;
      enSync  <= 1'h1;
      selMeta <= `LFMC_NOMINAL_STEP;
      selSync <= `LFMC_NOMINAL_STEP;
    end else begin
      enMeta  <= marginEnablePin;
      enSync  <= enMeta;
      selMeta <= marginSelectPin;
      selSync <= selMeta;
    end
  end

  // write decode
  wire logic wrCap1   = wr && (addr == `LFMC_ADDR_CAP1);
  wire logic wrRes3   = wr && (addr == `LFMC_ADDR_RES3);
  wire logic wrCap3   = wr && (addr == `LFMC_ADDR_CAP3);
  wire logic wrMargin = wr && (addr == `LFMC_ADDR_MARGIN);
  wire logic wrSwHi   = wr && (addr == `LFMC_ADDR_SW_HI);
  wire logic wrSwLo   = wr && (addr == `LFMC_ADDR_SW_LO);

  // filter registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filterCfg.synth2FilterCapFirst   <= `LFMC_RST_CAP;
      filterCfg.synth2FilterResThird   <= `LFMC_RST_RES;
      filterCfg.synth2FilterCapThird   <= `LFMC_RST_CAP;
      filterCfg.synth2FilterFracSelect <= `LFMC_RST_FRAC;
    end else begin
      if (wrCap1) begin
        filterCfg.synth2FilterCapFirst <=
          wdata[`LFMC_CAP_MSB:`LFMC_CAP_LSB];
      end
      if (wrRes3) begin
        filterCfg.synth2FilterResThird <=
          wdata[`LFMC_RES_MSB:`LFMC_RES_LSB];
        filterCfg.synth2FilterFracSelect <= wdata[`LFMC_FRAC_BIT];
      end
      if (wrCap3) begin
        filterCfg.synth2FilterCapThird <=
          wdata[`LFMC_CAP_MSB:`LFMC_CAP_LSB];
      end
    end
  end

  // margin source and software offset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      marginSrc <= lfmc_src_t'(`LFMC_RST_SRC);
      swHi      <= SW_RST[9:8];
      swLo      <= SW_RST[7:0];
    end else begin
      if (wrMargin) begin
        marginSrc <= lfmc_src_t'(wdata[`LFMC_SRC_MSB:`LFMC_SRC_LSB]);
      end
      if (wrSwHi) begin
        swHi <= wdata[1:0];
      end
      if (wrSwLo) begin
        swLo <= wdata;
      end
    end
  end

  // step offset registers, high byte at even address
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_step
      localparam logic [7:0] HI_ADDR = `LFMC_ADDR_STEP_BASE + 8'(2 * i);
      wire logic wrHi = wr && (addr == HI_ADDR);
      wire logic wrLo = wr && (addr == (HI_ADDR + 8'h01));
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stepHi[i] <= STEP_RST[i][9:8];
          stepLo[i] <= STEP_RST[i][7:0];
        end else begin
          if (wrHi) begin
            stepHi[i] <= wdata[1:0];
          end
          if (wrLo) begin
            stepLo[i] <= wdata;
          end
        end
      end
    end
  endgenerate

  // offset selection
  wire logic [9:0] selOffset  = {stepHi[selSync], stepLo[selSync]};
  wire logic [9:0] nomOffset  = {stepHi[`LFMC_NOMINAL_STEP],
                                 stepLo[`LFMC_NOMINAL_STEP]};
  wire logic [9:0] swOffset   = {swHi, swLo};
  wire logic       srcSw      = (marginSrc == LFMC_SRC_SW);
  wire logic       srcSelect  = (marginSrc == LFMC_SRC_SELECT);
  // codes 0 and 3 both gate with the enable pin
  wire logic       srcGated   = !srcSw && !srcSelect;
  wire logic       gatedOn    = !enSync;
  wire logic       next_active = srcGated ? gatedOn : 1'h1;
  wire logic [9:0] next_offset =
    srcSw     ? swOffset :
    srcSelect ? selOffset :
    gatedOn   ? selOffset : nomOffset;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      marginOut.active <= 1'h0;
      marginOut.step   <= `LFMC_NOMINAL_STEP;
      marginOut.offset <= `LFMC_RST_NOMINAL_OFFSET_STEP;
    end else begin
      marginOut.active <= next_active;
      marginOut.step   <= (srcGated && !gatedOn) ?
                          `LFMC_NOMINAL_STEP : selSync;
      marginOut.offset <= next_offset;
    end
  end

  // read selection
  wire logic       inStep   = (addr >= `LFMC_ADDR_STEP_BASE) &&
                              (addr <= `LFMC_ADDR_STEP_LAST);
  wire logic [7:0] stepOff  = addr - `LFMC_ADDR_STEP_BASE;
  wire logic [2:0] stepIdx  = stepOff[3:1];
  wire logic [7:0] stepByte = stepOff[0] ? stepLo[stepIdx] :
                              {6'h00, stepHi[stepIdx]};
  wire logic [7:0] rdCap1   = {5'h00, filterCfg.synth2FilterCapFirst};
  wire logic [7:0] rdRes3   = {1'h0, filterCfg.synth2FilterResThird,
                               filterCfg.synth2FilterFracSelect};
  wire logic [7:0] rdCap3   = {5'h00, filterCfg.synth2FilterCapThird};
  wire logic [7:0] rdMargin = {1'h0, selSync, marginSrc, 2'h0};
  wire logic [7:0] next_rdata =
    !rd                          ? 8'h00 :
    (addr == `LFMC_ADDR_CAP1)    ? rdCap1 :
    (addr == `LFMC_ADDR_RES3)    ? rdRes3 :
    (addr == `LFMC_ADDR_CAP3)    ? rdCap3 :
    (addr == `LFMC_ADDR_MARGIN)  ? rdMargin :
    (addr == `LFMC_ADDR_SW_HI)   ? {6'h00, swHi} :
    (addr == `LFMC_ADDR_SW_LO)   ? swLo :
    inStep                       ? stepByte : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

//--- tb/lfmc_pins.sv
// Purpose: board strap model driving the margining pins
// Assumes: pins move just after a clock edge
// Notes: none
`timescale 1ns/10ps
`default_nettype none
module lfmc_pins (
  // control
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [2:0] sel,
  // pins
  output var  logic       enPin,
  output var  logic [2:0] selPin
);
  initial enPin = 1'b1;
  initial selPin = 3'h3;
  always @(posedge clk) begin
    enPin <= en;
    selPin <= sel;
  end
endmodule
`default_nettype wire

//--- tb/lfmc_regs_sva.sv
// Purpose: port checker of the filter/margin bank
// Assumes: bound to lfmc_regs
// Notes: src mirrors the margin source field
`timescale 1ns/10ps
`default_nettype none
module lfmc_regs_chk (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   resetn,
  // register port
  input wire logic [7:0]             addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [7:0]             rdata,
  // pins and controls
  input wire logic                   marginEnablePin,
  input wire logic [2:0]             marginSelectPin,
  input wire lfmc_pkg::lfmc_filter_t filterCfg,
  input wire lfmc_pkg::lfmc_margin_t marginOut
);
  import lfmc_pkg::*;
  logic [1:0] src;
  wire        gated = src[0] ~^ src[1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) src <= 2'h0;
    else if (wr && addr == 8'h56) src <= wdata[3:2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_cap1_write: assert property (wr && addr == 8'h53 |=>
    filterCfg.synth2FilterCapFirst == $past(wdata[2:0])) else $error("cap1");
  chk_cap3_write: assert property (wr && addr == 8'h55 |=>
    filterCfg.synth2FilterCapThird == $past(wdata[2:0])) else $error("cap3");
  chk_res3_write: assert property (wr && addr == 8'h54 |=>
    {filterCfg.synth2FilterResThird, filterCfg.synth2FilterFracSelect}
    == $past(wdata[6:0])) else $error("res3");
  chk_margin_read: assert property (rd && addr == 8'h56 |=>
    rdata[7] == 1'b0 && rdata[1:0] == 2'h0 && rdata[3:2] == src)
    else $error("margin read");
  chk_gated_enable: assert property ($past(gated) |->
    marginOut.active == !$past(marginEnablePin, 3)) else $error("gate");
  chk_nominal_step: assert property (!marginOut.active |->
    marginOut.step == 3'h3) else $error("nominal");
  chk_pin_step: assert property ($past(src) != 2'h2 && marginOut.active
    |-> marginOut.step == $past(marginSelectPin, 3)) else $error("step");
  chk_select_on: assert property ($past(src) == 2'h1 |->
    marginOut.active) else $error("select");
  chk_soft_on: assert property ($past(src) == 2'h2 |->
    marginOut.active) else $error("soft");
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata idle");
  cover property (wr && addr == 8'h56 && wdata[3:2] == 2'h3);
  cover property ($past(src) == 2'h2 && marginOut.active);
  cover property (!marginOut.active);
endmodule
`default_nettype wire

//--- tb/loop_filter_margin_control_regs_test.sv
// Purpose: directed test of the filter/margin bank
// Assumes: strap model drives the pins
// Notes: checker bound at the foot
`timescale 1ns/10ps
`default_nettype none
`include "lfmc_params.svh"
module loop_filter_margin_control_regs_test;
  import lfmc_pkg::*;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic [7:0]   wdata = 8'h00;
  logic [7:0]   rdata;
  logic         en = 1'b1;
  logic [2:0]   sel = 3'h3;
  logic         enPin;
  logic [2:0]   selPin;
  lfmc_filter_t filterCfg;
  lfmc_margin_t marginOut;
  int           num_errors = 0;
  int           samples_checked = 0;
  logic [9:0]   stepVal [8] = '{`LFMC_RST_STEP1, `LFMC_RST_STEP2,
    `LFMC_RST_STEP3, `LFMC_RST_NOMINAL_OFFSET_STEP, `LFMC_RST_STEP5, `LFMC_RST_STEP6,
    `LFMC_RST_STEP7, `LFMC_RST_STEP8};
  always #2 clk = ~clk;
  lfmc_pins u_pins (.clk(clk), .en(en), .sel(sel), .enPin(enPin),
    .selPin(selPin));
  lfmc_regs u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .marginEnablePin(enPin),
    .marginSelectPin(selPin), .filterCfg(filterCfg), .marginOut(marginOut));
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task put(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task get(input logic [7:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task t_reset;
    get(8'h53, 8'h00);
    get(8'h54, 8'h00);
    get(8'h55, 8'h00);
    get(8'h56, 8'h30);
    get(8'h57, 8'h00);
  endtask
  task t_filter;
    put(8'h53, 8'hff);
    put(8'h54, 8'hff);
    put(8'h55, 8'hff);
    chk(filterCfg, 13'h1fff);
    get(8'h54, 8'h7f);
    get(8'h55, 8'h07);
    put(8'h56, 8'hff);
    get(8'h56, 8'h3c);
  endtask
  task t_margin;
    logic [2:0] k;
    logic [13:0] x;
    put(8'h62, 8'hff);
    put(8'h63, 8'h21);
    get(8'h62, 8'h03);
    stepVal[5] = 10'h321;
    put(8'h68, 8'h02);
    put(8'h69, 8'h5a);
    for (int s = 0; s < 4; s++) for (int e = 0; e < 2; e++) begin
      k = {s[1:0], e[0]};
      en <= e[0];
      sel <= k;
      put(8'h56, {4'h0, s[1:0], 2'h0});
      x = {1'b1, k, stepVal[k]};
      if (s == 2) x = {1'b1, k, 10'h25a};
      else if (e == 1 && s != 1) x = {1'b0, 3'h3, stepVal[3]};
      repeat (4) @(posedge clk);
      chk(marginOut, x);
      get(8'h56, {1'b0, k, s[1:0], 2'h0});
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    chk(marginOut, 14'h0d86);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_filter;
    t_margin;
    report_and_stop;
  end
  initial begin
    #10000;
    num_errors++;
    report_and_stop;
  end
endmodule
bind lfmc_regs lfmc_regs_chk u_chk (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .marginEnablePin(marginEnablePin), .marginSelectPin(marginSelectPin),
  .filterCfg(filterCfg), .marginOut(marginOut));
`default_nettype wire
